// >>> rtl/ccp_pkg.sv
`default_nettype none

package ccp_pkg;

    // unit control register layout
    localparam int          CTRL_W        = 6;
    localparam int          MODE_LSB      = 0;
    localparam int          MODE_MSB      = 3;
    localparam int          DUTY_LSB_LO   = 4;
    localparam int          DUTY_LSB_HI   = 5;
    localparam logic [5:0]  CTRL_RESET    = 6'h00;
    localparam logic [7:0]  CTRL_CLEARED  = 8'h00;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;

    // unit_mode_field codes
    localparam logic [3:0]  MODE_OFF         = 4'h0;
    localparam logic [3:0]  MODE_CMP_TOGGLE  = 4'h2;
    localparam logic [3:0]  MODE_CAP_FALL    = 4'h4;
    localparam logic [3:0]  MODE_CAP_RISE16  = 4'h7;
    localparam logic [3:0]  MODE_CMP_SET     = 4'h8;
    localparam logic [3:0]  MODE_CMP_CLR     = 4'h9;
    localparam logic [3:0]  MODE_CMP_SWINT   = 4'ha;
    localparam logic [3:0]  MODE_CMP_SPECIAL = 4'hb;
    localparam logic [1:0]  MODE_PWM_TOP     = 2'h3;

    // capture event selection, equal to unit_mode_field[1:0] in capture modes
    typedef enum logic [1:0] {
        EDGE_FALL   = 2'h0,
        EDGE_RISE   = 2'h1,
        EDGE_RISE4  = 2'h2,
        EDGE_RISE16 = 2'h3
    } cap_event_e;

    localparam int          PRESC_W       = 4;
    localparam logic [3:0]  PRESC_RESET   = 4'h0;
    localparam logic [3:0]  PRESC_STEP    = 4'h1;
    localparam logic [1:0]  PRESC4_LAST   = 2'h3;
    localparam logic [3:0]  PRESC16_LAST  = 4'hf;

    // timer_select_field codes and timer indices
    localparam int          CC_TIMERS     = 2;
    localparam int          PWM_TIMERS    = 3;
    localparam logic [1:0]  TSEL_A        = 2'h0;
    localparam logic [1:0]  TSEL_B        = 2'h1;
    localparam logic [1:0]  TSEL_C        = 2'h2;
    localparam logic [0:0]  CC_IDX_0      = 1'h0;
    localparam logic [0:0]  CC_IDX_1      = 1'h1;
    localparam logic [1:0]  PWM_IDX_0     = 2'h0;
    localparam logic [1:0]  PWM_IDX_1     = 2'h1;
    localparam logic [1:0]  PWM_IDX_2     = 2'h2;
    localparam logic [9:0]  DUTY_ZERO     = 10'h000;
    localparam logic [9:0]  DUTY_ONE      = 10'h001;

endpackage

`default_nettype wire

// >>> rtl/capture_if.sv
`timescale 1ns/10ps
`default_nettype none

interface capture_if;
    logic                sample;
    logic                armed;
    ccp_pkg::cap_event_e sel;
    logic                hit;

    modport ctl (output sample, output armed, output sel, input hit);
    modport det (input sample, input armed, input sel, output hit);
endinterface

`default_nettype wire

// >>> rtl/capture_edge_unit.sv
`timescale 1ns/10ps
`default_nettype none

module capture_edge_unit (
    input  wire logic   ref_clk,
    input  wire logic   rst,
    input  wire logic   clk_en,
    capture_if.det      cap
);

    typedef struct packed {
        logic                          sync1;
        logic                          sync2;
        logic                          last;
        logic [ccp_pkg::PRESC_W-1:0]   cnt;
        logic                          hit;
    } edge_state_s;

    edge_state_s q;
    edge_state_s d;
    logic        rise;
    logic        fall;

    always_comb begin
        d       = q;
        d.sync1 = cap.sample;
        d.sync2 = q.sync1;
        d.last  = q.sync2;
        // edges seen only after the second flop, one count per rising edge
        rise    = q.sync2 & ~q.last;
        fall    = ~q.sync2 & q.last;
        d.hit   = 1'h0;
        if (!cap.armed) begin
            d.cnt = ccp_pkg::PRESC_RESET;
        end else begin
            // a change between capture settings keeps the count running
            if (rise) begin
                d.cnt = q.cnt + ccp_pkg::PRESC_STEP;
            end
            unique case (cap.sel)
                ccp_pkg::EDGE_FALL:   d.hit = fall;
                ccp_pkg::EDGE_RISE:   d.hit = rise;
                ccp_pkg::EDGE_RISE4:  d.hit = rise && (q.cnt[1:0] == ccp_pkg::PRESC4_LAST);
                ccp_pkg::EDGE_RISE16: d.hit = rise && (q.cnt == ccp_pkg::PRESC16_LAST);
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign cap.hit = q.hit;

endmodule

`default_nettype wire

// >>> rtl/capture_compare_pwm_unit.sv
`timescale 1ns/10ps
`default_nettype none

// Function
// - each capture event copies the full 16-bit selected timer into both data bytes
// - capture on every falling, rising, 4th rising or 16th rising pin edge
// - capture sets the event flag; only software clears it
// - a later capture overwrites an unread earlier one without protection
// - with the pin as output, port writes that change it can trigger capture
// - prescaler counter cleared when unit off or not capturing, so reset clears it
// - switching between capture prescalers keeps the counter; may raise the flag
// - compare data pair to timer; match sets flag and drives pin per mode
// - clearing the control register forces the compare output latch low
// - mode 1010 match leaves the pin alone and only sets the flag
// - mode 1011 match pulses a trigger that resets the selected timer
// - the special event trigger does not start any analog conversion
// - pwm period is (limit+1) times four oscillator periods times timer prescale
// - after timebase equals limit: clear timebase, set pin unless 0%, latch duty
// - the timebase postscaler does not affect the pwm period
// - duty is 10 bits: low byte gives eight msbs, control bits 5:4 the lsbs
// - high time is duty value times oscillator period times prescale
// - duty writes take effect at period end; high byte read-only in pwm mode
// - pin clears when latched high byte and 2-bit latch equal timebase plus phase
// - a duty beyond the period never clears the pin, output stays high
// - a select field picks the 16-bit timer and the 8-bit pwm timer
module capture_compare_pwm_unit (
    input  wire logic                                  ref_clk,
    input  wire logic                                  rst,
    input  wire logic                                  clk_en,
    input  wire logic                                  ctrl_wr,
    input  wire logic [7:0]                            ctrl_wdata,
    input  wire logic                                  data_low_wr,
    input  wire logic [7:0]                            data_low_wdata,
    input  wire logic                                  data_high_wr,
    input  wire logic [7:0]                            data_high_wdata,
    input  wire logic                                  flag_clear,
    input  wire logic                                  unit_irq_enable,
    input  wire logic [1:0]                            timer_select_field,
    input  wire logic [ccp_pkg::CC_TIMERS-1:0][15:0]   cc_timer,
    input  wire logic [ccp_pkg::PWM_TIMERS-1:0][7:0]   pwm_timebase_count,
    input  wire logic [ccp_pkg::PWM_TIMERS-1:0][7:0]   pwm_period_limit,
    input  wire logic [ccp_pkg::PWM_TIMERS-1:0]        pwm_timebase_inc,
    input  wire logic [ccp_pkg::PWM_TIMERS-1:0][1:0]   pwm_phase,
    input  wire logic                                  unit_pin_in,
    input  wire logic                                  port_latch,
    input  wire logic                                  pin_direction_bit,
    output logic                                       unit_pin_out,
    output logic                                       unit_pin_oe_n,
    output logic [7:0]                                 unit_control_reg,
    output logic [7:0]                                 data_low_byte,
    output logic [7:0]                                 data_high_byte,
    output logic                                       unit_event_flag,
    output logic                                       unit_irq,
    output logic [ccp_pkg::CC_TIMERS-1:0]              cc_timer_reset,
    output logic [ccp_pkg::PWM_TIMERS-1:0]             pwm_timebase_reset
);

    typedef struct packed {
        logic [ccp_pkg::CTRL_W-1:0]      ctrl;
        logic [7:0]                      lo;
        logic [7:0]                      hi;
        logic [1:0]                      duty_lsb;
        logic                            out_latch;
        logic                            flag;
        logic                            eq_q;
        logic [ccp_pkg::CC_TIMERS-1:0]   cc_rst;
        logic [ccp_pkg::PWM_TIMERS-1:0]  pwm_rst;
    } unit_state_s;

    unit_state_s  q;
    unit_state_s  d;
    capture_if    cap ();

    logic [3:0]   mode;
    logic         is_cap;
    logic         is_cmp;
    logic         is_pwm;
    logic [0:0]   cc_idx;
    logic [1:0]   pwm_idx;
    logic [15:0]  cc_now;
    logic         cmp_eq;
    logic         cmp_hit;
    logic         pwm_roll;
    logic         pwm_match;
    logic         drive_latch;
    logic [9:0]   duty_next;
    logic [9:0]   duty_end;

    assign mode   = q.ctrl[ccp_pkg::MODE_MSB:ccp_pkg::MODE_LSB];
    assign is_cap = (mode >= ccp_pkg::MODE_CAP_FALL) && (mode <= ccp_pkg::MODE_CAP_RISE16);
    assign is_pwm = (mode[3:2] == ccp_pkg::MODE_PWM_TOP);
    assign is_cmp = (mode == ccp_pkg::MODE_CMP_TOGGLE)
                 || ((mode >= ccp_pkg::MODE_CMP_SET) && (mode <= ccp_pkg::MODE_CMP_SPECIAL));

    // reserved select code falls back to the first pair
    always_comb begin
        unique case (timer_select_field)
            ccp_pkg::TSEL_A: begin
                cc_idx  = ccp_pkg::CC_IDX_0;
                pwm_idx = ccp_pkg::PWM_IDX_0;
            end
            ccp_pkg::TSEL_B: begin
                cc_idx  = ccp_pkg::CC_IDX_1;
                pwm_idx = ccp_pkg::PWM_IDX_1;
            end
            ccp_pkg::TSEL_C: begin
                cc_idx  = ccp_pkg::CC_IDX_1;
                pwm_idx = ccp_pkg::PWM_IDX_2;
            end
            default: begin
                cc_idx  = ccp_pkg::CC_IDX_0;
                pwm_idx = ccp_pkg::PWM_IDX_0;
            end
        endcase
    end

    // timer value is used as-is; it must already be in this clock domain
    assign cc_now  = cc_timer[cc_idx];
    assign cmp_eq  = (cc_now == {q.hi, q.lo});
    // timer holds a value for several cycles; act once per arrival at the match
    assign cmp_hit = is_cmp && cmp_eq && !q.eq_q;

    // only the increment pulse and the count are seen, never a postscaler output
    assign pwm_roll  = pwm_timebase_inc[pwm_idx]
                    && (pwm_timebase_count[pwm_idx] == pwm_period_limit[pwm_idx]);
    // clear is registered: match one step early so the pin falls as the count reaches the duty
    assign duty_end  = {q.hi, q.duty_lsb} - ccp_pkg::DUTY_ONE;
    // a duty above {limit, phase} never matches, so the pin stays high
    assign pwm_match = (duty_end
                     == {pwm_timebase_count[pwm_idx], pwm_phase[pwm_idx]});
    assign duty_next = {q.lo, q.ctrl[ccp_pkg::DUTY_LSB_HI:ccp_pkg::DUTY_LSB_LO]};

    // with the pin driven, the capture path sees the port latch it drives
    assign cap.sample = pin_direction_bit ? unit_pin_in : port_latch;
    assign cap.armed  = is_cap;
    assign cap.sel    = ccp_pkg::cap_event_e'(mode[1:0]);

    capture_edge_unit edge_detect (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .cap     (cap.det)
    );

    always_comb begin
        d         = q;
        d.eq_q    = cmp_eq;
        d.cc_rst  = '0;
        d.pwm_rst = '0;

        if (ctrl_wr) begin
            d.ctrl = ctrl_wdata[ccp_pkg::CTRL_W-1:0];
            if (ctrl_wdata == ccp_pkg::CTRL_CLEARED) begin
                d.out_latch = 1'h0;
            end
        end
        if (data_low_wr) begin
            d.lo = data_low_wdata;
        end
        if (data_high_wr && !is_pwm) begin
            d.hi = data_high_wdata;
        end
        if (flag_clear) begin
            d.flag = 1'h0;
        end

        // hardware updates below override a same-cycle software write or clear
        if (is_cap && cap.hit) begin
            d.hi   = cc_now[15:8];
            d.lo   = cc_now[7:0];
            d.flag = 1'h1;
        end

        if (cmp_hit) begin
            d.flag = 1'h1;
            unique case (mode)
                ccp_pkg::MODE_CMP_SET:     d.out_latch = 1'h1;
                ccp_pkg::MODE_CMP_CLR:     d.out_latch = 1'h0;
                ccp_pkg::MODE_CMP_TOGGLE:  d.out_latch = ~q.out_latch;
                // trigger goes to the timer only; no converter start exists
                ccp_pkg::MODE_CMP_SPECIAL: d.cc_rst[cc_idx] = 1'h1;
                default:                   d.out_latch = q.out_latch;
            endcase
        end

        if (is_pwm) begin
            if (pwm_roll) begin
                d.pwm_rst[pwm_idx] = 1'h1;
                d.hi               = q.lo;
                d.duty_lsb         = q.ctrl[ccp_pkg::DUTY_LSB_HI:ccp_pkg::DUTY_LSB_LO];
                // a zero duty also drops a pin left high by a full-high period
                d.out_latch = (duty_next != ccp_pkg::DUTY_ZERO);
            end else if (pwm_match) begin
                d.out_latch = 1'h0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q          <= '0;
            q.ctrl     <= ccp_pkg::CTRL_RESET;
            q.lo       <= ccp_pkg::BYTE_RESET;
            q.hi       <= ccp_pkg::BYTE_RESET;
        end else if (clk_en) begin
            q <= d;
        end
    end

    // swint and special modes leave the pin following the port latch
    assign drive_latch = is_pwm
                      || (is_cmp && (mode != ccp_pkg::MODE_CMP_SWINT)
                                 && (mode != ccp_pkg::MODE_CMP_SPECIAL));

    assign unit_pin_out       = drive_latch ? q.out_latch : port_latch;
    assign unit_pin_oe_n      = pin_direction_bit;
    assign unit_control_reg   = {2'h0, q.ctrl};
    assign data_low_byte      = q.lo;
    assign data_high_byte     = q.hi;
    assign unit_event_flag    = q.flag;
    assign unit_irq           = q.flag & unit_irq_enable;
    assign cc_timer_reset     = q.cc_rst;
    assign pwm_timebase_reset = q.pwm_rst;

endmodule

`default_nettype wire

// >>> tb/ccp_unit_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module ccp_unit_asserts (
    input wire logic                                ref_clk,
    input wire logic                                rst,
    input wire logic                                flag_clear,
    input wire logic                                unit_irq_enable,
    input wire logic [1:0]                          timer_select_field,
    input wire logic [ccp_pkg::CC_TIMERS-1:0][15:0] cc_timer,
    input wire logic                                port_latch,
    input wire logic                                unit_pin_out,
    input wire logic [7:0]                          unit_control_reg,
    input wire logic [7:0]                          data_low_byte,
    input wire logic [7:0]                          data_high_byte,
    input wire logic                                unit_event_flag,
    input wire logic                                unit_irq,
    input wire logic [ccp_pkg::CC_TIMERS-1:0]       cc_timer_reset,
    input wire logic [ccp_pkg::PWM_TIMERS-1:0]      pwm_timebase_reset
);
    // mode and timer value as seen at the edge that took the event
    logic [7:0]  ctrl_q;
    logic [15:0] cap_q;
    always_ff @(posedge ref_clk) begin
        ctrl_q <= unit_control_reg;
        cap_q  <= cc_timer[^timer_select_field];
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_irq_gate;
        unit_irq == (unit_event_flag && unit_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not flag and enable");
    property p_flag_sticky;
        unit_event_flag && !flag_clear |=> unit_event_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
    property p_high_readonly;
        ctrl_q[3:2] == 2'h3 && $changed(data_high_byte) |-> |pwm_timebase_reset;
    endproperty
    a_high_readonly: assert property (p_high_readonly) else $error("high byte moved in pwm");
    property p_rollover;
        |pwm_timebase_reset |-> data_high_byte == $past(data_low_byte)
            && unit_pin_out == ({$past(data_low_byte), ctrl_q[5:4]} != 10'h000);
    endproperty
    a_rollover: assert property (p_rollover) else $error("bad period rollover");
    property p_swint_pin;
        unit_control_reg[3:0] == 4'ha && ctrl_q[3:0] == 4'ha && $stable(port_latch)
            |-> unit_pin_out == port_latch;
    endproperty
    a_swint_pin: assert property (p_swint_pin) else $error("pin moved in mode a");
    property p_special;
        |cc_timer_reset |-> ctrl_q[3:0] == 4'hb && unit_event_flag
            && cc_timer_reset[^timer_select_field];
    endproperty
    a_special: assert property (p_special) else $error("stray timer reset");
    property p_capture_value;
        $rose(unit_event_flag) && ctrl_q[3:2] == 2'h1 |-> {data_high_byte, data_low_byte} == cap_q;
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("captured wrong value");
    property p_compare_pin;
        $rose(unit_event_flag) && ctrl_q[3:1] == 3'h4 |-> unit_pin_out == !ctrl_q[0];
    endproperty
    a_compare_pin: assert property (p_compare_pin) else $error("compare pin wrong");
endmodule

bind capture_compare_pwm_unit ccp_unit_asserts checker_inst (.ref_clk, .rst, .flag_clear, .unit_irq_enable,
    .timer_select_field, .cc_timer, .port_latch, .unit_pin_out, .unit_control_reg, .data_low_byte,
    .data_high_byte, .unit_event_flag, .unit_irq, .cc_timer_reset, .pwm_timebase_reset);

`default_nettype wire

// >>> tb/ccp_timer_model.sv
`timescale 1ns/10ps
`default_nettype none

module ccp_timer_model (
    input  wire logic                                ref_clk,
    input  wire logic                                rst,
    input  wire logic [ccp_pkg::CC_TIMERS-1:0]       cc_timer_reset,
    input  wire logic [ccp_pkg::PWM_TIMERS-1:0]      pwm_timebase_reset,
    input  wire logic [ccp_pkg::PWM_TIMERS-1:0][7:0] pwm_period_limit,
    output logic [ccp_pkg::CC_TIMERS-1:0][15:0]      cc_timer,
    output logic [ccp_pkg::PWM_TIMERS-1:0][7:0]      pwm_timebase_count,
    output logic [ccp_pkg::PWM_TIMERS-1:0]           pwm_timebase_inc,
    output logic [ccp_pkg::PWM_TIMERS-1:0][1:0]      pwm_phase
);
    // all counts move on ref_clk only, never as an asynchronous counter
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < ccp_pkg::CC_TIMERS; i++) begin
            if (rst || cc_timer_reset[i]) begin
                cc_timer[i] <= 16'h0000;
            end else begin
                cc_timer[i] <= cc_timer[i] + 16'(2 * i + 1);
            end
        end
        for (int j = 0; j < ccp_pkg::PWM_TIMERS; j++) begin
            pwm_phase[j] <= rst ? 2'h0 : pwm_phase[j] + 2'h1;
            if (rst || pwm_timebase_reset[j]) begin
                pwm_timebase_count[j] <= 8'h00;
            end else if (pwm_timebase_inc[j]) begin
                pwm_timebase_count[j] <= (pwm_timebase_count[j] == pwm_period_limit[j]) ? 8'h00
                                         : pwm_timebase_count[j] + 8'h01;
            end
        end
    end
    // one increment per four phases, prescale of 1
    always_comb begin
        for (int k = 0; k < ccp_pkg::PWM_TIMERS; k++) begin
            pwm_timebase_inc[k] = (pwm_phase[k] == 2'h3);
        end
    end
endmodule

`default_nettype wire

// >>> tb/capture_compare_pwm_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none

module capture_compare_pwm_unit_tb;
    logic            ref_clk, rst, ctrl_wr, data_low_wr, data_high_wr, flag_clear, unit_irq_enable;
    logic            pad, port_latch, pin_direction_bit, unit_pin_out, unit_pin_oe_n, unit_event_flag, unit_irq;
    logic [7:0]      wdata, unit_control_reg, data_low_byte, data_high_byte;
    logic [1:0]      timer_select_field, cc_timer_reset;
    logic [1:0][15:0] cc_timer;
    logic [2:0][7:0] pwm_timebase_count, pwm_period_limit;
    logic [2:0][1:0] pwm_phase;
    logic [2:0]      pwm_timebase_inc, pwm_timebase_reset;
    int              fail_count = 0;
    int              checks_done = 0;
    int              cyc = 0;

    capture_compare_pwm_unit dut (.ref_clk, .rst, .clk_en(1'h1), .ctrl_wr, .ctrl_wdata(wdata), .data_low_wr,
        .data_low_wdata(wdata), .data_high_wr, .data_high_wdata(wdata), .flag_clear, .unit_irq_enable,
        .timer_select_field, .cc_timer, .pwm_timebase_count, .pwm_period_limit, .pwm_timebase_inc, .pwm_phase,
        .unit_pin_in(pad), .port_latch, .pin_direction_bit, .unit_pin_out, .unit_pin_oe_n, .unit_control_reg,
        .data_low_byte, .data_high_byte, .unit_event_flag, .unit_irq, .cc_timer_reset, .pwm_timebase_reset);
    ccp_timer_model timers (.ref_clk, .rst, .cc_timer_reset, .pwm_timebase_reset, .pwm_period_limit,
        .cc_timer, .pwm_timebase_count, .pwm_timebase_inc, .pwm_phase);

    initial begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end

    // whole run needs about 750 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask

    // idle cycle after each strobe so no strobe is set twice in one step
    task automatic wr(input int k, input logic [7:0] d);
        {flag_clear, data_high_wr, data_low_wr, ctrl_wr} = 4'(1 << k);
        wdata = d;
        step(1);
        {flag_clear, data_high_wr, data_low_wr, ctrl_wr} = 4'h0;
        step(1);
    endtask

    task automatic set_mode(input logic [7:0] m);
        unit_irq_enable = 1'h0;
        wr(0, m);
        chk("ctrl readback", 16'({2'h0, m[5:0]}), 16'(unit_control_reg));
        wr(3, 8'h00);
    endtask

    task automatic rises(input int n);
        repeat (n) begin
            pad = 1'h1;
            step(3);
            pad = 1'h0;
            step(3);
        end
    endtask

    task automatic wait_roll();
        step(1);
        for (int w = 0; w < 100 && !(|pwm_timebase_reset); w++) begin
            step(1);
        end
    endtask

    task automatic test_capture();
        for (int m = 4; m < 8; m++) begin
            timer_select_field = 2'(m - 4);
            set_mode(8'h00);
            set_mode(8'(m));
            rises((m == 6) ? 3 : (m == 7) ? 15 : 0);
            chk("no early capture", 16'h0000, 16'(unit_event_flag));
            pad = 1'h1;
            step(6);
            chk("flag on rise", 16'(m != 4), 16'(unit_event_flag));
            pad = 1'h0;
            step(6);
            chk("flag after event", 16'h0001, 16'(unit_event_flag));
            unit_irq_enable = 1'h1;
            step(2);
            chk("irq", 16'h0001, 16'(unit_irq));
        end
        set_mode(8'h00);
        set_mode(8'h07);
        rises(3);
        set_mode(8'h06);
        rises(1);
        chk("switch keeps count", 16'h0001, 16'(unit_event_flag));
        $display("capture done");
    endtask

    task automatic test_overwrite();
        logic [15:0] first;
        pin_direction_bit = 1'h0;
        set_mode(8'h05);
        port_latch = 1'h1;
        step(6);
        chk("port write capture", 16'h0001, 16'(unit_event_flag));
        first = {data_high_byte, data_low_byte};
        port_latch = 1'h0;
        step(9);
        port_latch = 1'h1;
        step(6);
        chk("overwrite", 16'h0001, 16'(first !== {data_high_byte, data_low_byte}));
        chk("pin enable", 16'h0000, 16'(unit_pin_oe_n));
        port_latch = 1'h0;
        $display("overwrite done");
    endtask

    task automatic test_compare();
        logic [7:0]  modes [5] = '{8'h08, 8'h09, 8'h02, 8'h0a, 8'h0b};
        logic        pins [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
        logic [15:0] t;
        timer_select_field = 2'h0;
        for (int i = 0; i < 5; i++) begin
            set_mode(modes[i]);
            t = cc_timer[0] + 16'h0028;
            wr(1, t[7:0]);
            wr(2, t[15:8]);
            for (int w = 0; w < 60 && unit_event_flag !== 1'h1; w++) begin
                step(1);
            end
            chk("compare flag", 16'h0001, 16'(unit_event_flag));
            chk("compare pin", 16'(pins[i]), 16'(unit_pin_out));
        end
        step(1);
        chk("timer restarted", 16'h0001, 16'(cc_timer[0] < 16'h0008));
        set_mode(8'h00);
        set_mode(8'h08);
        chk("latch cleared", 16'h0000, 16'(unit_pin_out));
        $display("compare done");
    endtask

    task automatic test_pwm();
        logic [9:0] duty [4] = '{10'h006, 10'h015, 10'h000, 10'h017};
        logic [1:0] sel [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        int         per;
        int         high;
        int         n;
        for (int i = 0; i < 4; i++) begin
            timer_select_field = sel[i];
            per = 4 * (pwm_period_limit[(sel[i] == 2'h3) ? 2'h0 : sel[i]] + 1);
            wr(1, duty[i][9:2]);
            set_mode({2'h0, duty[i][1:0], 4'(12 + i)});
            wait_roll();
            wait_roll();
            chk("duty latched", 16'(duty[i][9:2]), 16'(data_high_byte));
            high = int'(unit_pin_out);
            n = 1;
            step(1);
            while (!(|pwm_timebase_reset) && n < 300) begin
                high += int'(unit_pin_out);
                n++;
                step(1);
            end
            chk("pwm period", 16'(per), 16'(n));
            chk("pwm high", 16'((duty[i] < per) ? duty[i] : per), 16'(high));
            wr(2, 8'hff);
            chk("high byte read only", 16'(duty[i][9:2]), 16'(data_high_byte));
        end
        $display("pwm done");
    endtask

    initial begin
        rst = 1'h1;
        {ctrl_wr, data_low_wr, data_high_wr, flag_clear, unit_irq_enable, pad, port_latch} = 7'h00;
        pin_direction_bit = 1'h1;
        wdata = 8'h00;
        timer_select_field = 2'h0;
        pwm_period_limit = {8'h05, 8'h04, 8'h03};
        step(2);
        rst = 1'h0;
        chk("reset ctrl and low", 16'h0000, {unit_control_reg, data_low_byte});
        chk("reset high and flag", 16'h0000, {data_high_byte, 7'h00, unit_event_flag});
        test_capture();
        test_overwrite();
        test_compare();
        test_pwm();
        close_out();
    end
endmodule

`default_nettype wire
